// ==== logic/mcdt_regs.vh ====
// register offsets, field positions and reset values for the timer block
`ifndef MCDT_REGS_VH
`define MCDT_REGS_VH
// register byte offsets within the module window
`define MCDT_OFS_MC_SIC 8'h10
`define MCDT_OFS_MC_CNT 8'h12
`define MCDT_OFS_MC_ML 8'h14
`define MCDT_OFS_DA_SIC 8'h18
`define MCDT_OFS_DA_A 8'h1a
`define MCDT_OFS_DA_B 8'h1c
// common status/control field positions
`define MCDT_FLAG_BIT 15
`define MCDT_LVL_HI 14
`define MCDT_LVL_LO 12
`define MCDT_ARB3_BIT 11
// modulus counter control fields
`define MCDT_DRIVE_A_BIT 9
`define MCDT_DRIVE_B_BIT 8
`define MCDT_CLK_PIN_BIT 7
`define MCDT_LOAD_PIN_BIT 6
`define MCDT_LD_FALL_BIT 5
`define MCDT_LD_RISE_BIT 4
`define MCDT_CLK_HI 2
`define MCDT_CLK_LO 0
// dual-action control fields
`define MCDT_WOR_BIT 9
`define MCDT_BUS_SEL_BIT 8
`define MCDT_IN_BIT 7
`define MCDT_FORCE_A_BIT 6
`define MCDT_FORCE_B_BIT 5
`define MCDT_POL_BIT 4
`define MCDT_MODE_HI 3
`define MCDT_MODE_LO 0
// dual-action mode codes
`define MCDT_MODE_OFF 4'h0
`define MCDT_MODE_IPW 4'h1
`define MCDT_MODE_PER 4'h2
`define MCDT_MODE_CAP 4'h3
`define MCDT_MODE_CMPB 4'h4
`define MCDT_MODE_CMPAB 4'h5
// clock select codes for the external pin
`define MCDT_CLK_EXT_FALL 3'h6
`define MCDT_CLK_EXT_RISE 3'h7
// reset values and limits
`define MCDT_ML_RESET 16'h0000
`define MCDT_CNT_RESET 16'h0000
`define MCDT_CNT_MAX 16'hffff
`define MCDT_LVL_OFF 3'h0
`endif

// ==== logic/mcdt_dual.v ====
// dual-action capture/compare channel with its own control register
`timescale 1ns/100ps
`include "mcdt_regs.vh"
module mcdt_dual (
    // clock and reset
    input wire clk,
    input wire rstn,
    // register strobes from the top decoder
    input wire sic_wr,
    input wire sic_rd,
    input wire a_wr,
    input wire b_wr,
    input wire [15:0] wdata,
    // time base buses
    input wire [15:0] tbb_a,
    input wire [15:0] tbb_b,
    // channel pin
    input wire pin_in,
    output wire pin_out,
    output wire pin_oe,
    // register views and interrupt state
    output wire [15:0] sic_val,
    output wire [15:0] a_val,
    output wire [15:0] b_val,
    output wire flag,
    output wire [2:0] irq_lvl
);
    reg flag_reg, armed_reg, arb3_reg, wor_reg, bus_sel_reg, pol_reg;
    reg [2:0] irq_lvl_reg;
    reg [3:0] mode_reg;
    reg [15:0] a_reg, b_reg;
    reg ena_a_reg, ena_b_reg, first_reg, drv_reg;
    reg s1_reg, s2_reg, s3_reg, lvl_reg;
    wire [15:0] tb;
    wire rise, fall, in_mode, out_mode, pwm_mode, edge_a, edge_b;
    wire cap_a, cap_b, match_a, match_b, fa, fb, set_ev;
    wire [15:0] msk;
    wire [3:0] mode_next;

    // compare mask per output resolution
    function [15:0] res_mask;
        input [3:0] m;
        begin
            case (m[2:0])
                3'h0: res_mask = 16'hffff;
                3'h1: res_mask = 16'h7fff;
                3'h2: res_mask = 16'h3fff;
                3'h3: res_mask = 16'h1fff;
                3'h4: res_mask = 16'h0fff;
                3'h5: res_mask = 16'h07ff;
                3'h6: res_mask = 16'h01ff;
                default: res_mask = 16'h007f;
            endcase
        end
    endfunction

    assign tb = bus_sel_reg ? tbb_b : tbb_a;
    assign pwm_mode = mode_reg[3];
    assign in_mode = (mode_reg == `MCDT_MODE_IPW) ||
        (mode_reg == `MCDT_MODE_PER) || (mode_reg == `MCDT_MODE_CAP);
    assign out_mode = pwm_mode || (mode_reg == `MCDT_MODE_CMPB) ||
        (mode_reg == `MCDT_MODE_CMPAB);
    assign rise = lvl_reg == 1'b0 && s2_reg == s3_reg && s2_reg == 1'b1;
    assign fall = lvl_reg == 1'b1 && s2_reg == s3_reg && s2_reg == 1'b0;
    assign edge_a = pol_reg ? fall : rise;
    assign edge_b = pol_reg ? rise : fall;
    assign cap_a = in_mode && edge_a;
    assign cap_b = (mode_reg == `MCDT_MODE_IPW) && edge_b;
    assign msk = res_mask(mode_reg);
    assign match_a = pwm_mode ? ((tb & msk) == (a_reg & msk)) :
        (out_mode && ena_a_reg && tb == a_reg);
    assign match_b = pwm_mode ? ((tb & msk) == (b_reg & msk)) :
        (out_mode && ena_b_reg && tb == b_reg);
    // force bits only in output modes
    assign fa = sic_wr && out_mode && wdata[`MCDT_FORCE_A_BIT];
    assign fb = sic_wr && out_mode && wdata[`MCDT_FORCE_B_BIT];
    assign mode_next = sic_wr ? wdata[`MCDT_MODE_HI:`MCDT_MODE_LO] : mode_reg;
    assign set_ev = ((mode_reg == `MCDT_MODE_IPW ||
        mode_reg == `MCDT_MODE_CAP) && cap_a) ||
        ((mode_reg == `MCDT_MODE_PER) && cap_a && first_reg) ||
        ((mode_reg == `MCDT_MODE_CMPB) && match_b) ||
        ((mode_reg == `MCDT_MODE_CMPAB) && (match_a || match_b)) ||
        (pwm_mode && match_a);

    // pin sync, three stages; two last must agree
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            lvl_reg <= 1'b0;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                lvl_reg <= s3_reg;
            end
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag_reg <= 1'b0;
            armed_reg <= 1'b0;
            irq_lvl_reg <= `MCDT_LVL_OFF;
            arb3_reg <= 1'b0;
            wor_reg <= 1'b0;
            bus_sel_reg <= 1'b0;
            pol_reg <= 1'b0;
            mode_reg <= `MCDT_MODE_OFF;
            a_reg <= 16'h0000;
            b_reg <= 16'h0000;
            ena_a_reg <= 1'b0;
            ena_b_reg <= 1'b0;
            first_reg <= 1'b0;
            drv_reg <= 1'b0;
        end else begin
            if (sic_wr) begin
                irq_lvl_reg <= wdata[`MCDT_LVL_HI:`MCDT_LVL_LO];
                arb3_reg <= wdata[`MCDT_ARB3_BIT];
                // kept and read back in every mode
                wor_reg <= wdata[`MCDT_WOR_BIT];
                bus_sel_reg <= wdata[`MCDT_BUS_SEL_BIT];
                pol_reg <= wdata[`MCDT_POL_BIT];
                mode_reg <= mode_next;
            end
            // set wins over clear; disabled holds it low
            if (mode_next == `MCDT_MODE_OFF) begin
                flag_reg <= 1'b0;
            end else if (set_ev) begin
                flag_reg <= 1'b1;
            end else if (sic_wr && armed_reg && !wdata[`MCDT_FLAG_BIT]) begin
                flag_reg <= 1'b0;
            end
            if (sic_rd && flag_reg) begin
                armed_reg <= 1'b1;
            end else if (sic_wr) begin
                armed_reg <= 1'b0;
            end
            // period mode skips the flag on its first capture
            if (mode_reg != `MCDT_MODE_PER) begin
                first_reg <= 1'b0;
            end else if (cap_a) begin
                first_reg <= 1'b1;
            end
            // captures override a same-cycle software write
            if (cap_a) begin
                a_reg <= tb;
            end else if (a_wr) begin
                a_reg <= wdata;
            end
            if (cap_b) begin
                b_reg <= tb;
            end else if (cap_a && mode_reg == `MCDT_MODE_PER) begin
                b_reg <= a_reg;
            end else if (b_wr) begin
                b_reg <= wdata;
            end
            // one-shot comparators armed by a data write
            if (a_wr) begin
                ena_a_reg <= 1'b1;
            end else if (match_a) begin
                ena_a_reg <= 1'b0;
            end
            if (b_wr) begin
                ena_b_reg <= 1'b1;
            end else if (match_b) begin
                ena_b_reg <= 1'b0;
            end
            // output flip-flop; both forces reset it
            if (fa && fb) begin
                drv_reg <= pol_reg;
            end else if (match_b || fb) begin
                drv_reg <= pol_reg;
            end else if (match_a || fa) begin
                drv_reg <= ~pol_reg;
            end
        end
    end

    // open-drain only releases the high level
    assign pin_oe = out_mode && (!wor_reg || !drv_reg);
    assign pin_out = drv_reg;
    // pin status source depends on mode
    assign sic_val = {flag_reg, irq_lvl_reg, arb3_reg, 1'b0, wor_reg,
        bus_sel_reg, (out_mode ? drv_reg : lvl_reg), 2'b00, pol_reg,
        mode_reg};
    assign a_val = a_reg;
    assign b_val = b_reg;
    assign flag = flag_reg;
    assign irq_lvl = irq_lvl_reg;
endmodule // mcdt_dual

// ==== logic/mcdt_top.v ====
// modulus counter, register access and dual-action channel of the timer
`timescale 1ns/100ps
`include "mcdt_regs.vh"
module mcdt_top (
    // clock and reset
    input wire clk,
    input wire rstn,
    // submodule register bus
    input wire bus_sel,
    input wire bus_wr,
    input wire [7:0] bus_addr,
    input wire [15:0] bus_wdata,
    output reg [15:0] bus_rdata,
    output reg bus_ack,
    // prescaler tap pulses, same clock
    input wire [5:0] pclk_tick,
    // module-wide arbitration field
    input wire [2:0] module_arb_field,
    // counter pins
    input wire external_counter_clock_pin,
    input wire modulus_load_pin,
    // time base buses
    input wire [15:0] tbb_a_in,
    input wire [15:0] tbb_b_in,
    output reg [15:0] tbb_a_out,
    output reg tbb_a_oe,
    output reg [15:0] tbb_b_out,
    output reg tbb_b_oe,
    // dual-action channel pin
    input wire da_pin_in,
    output wire da_pin_out,
    output wire da_pin_oe,
    // interrupt request and acknowledge
    output wire [7:1] irq_req,
    input wire iack_strobe,
    input wire [2:0] iack_level,
    output wire mc_iack_hit,
    output wire da_iack_hit,
    output wire [3:0] mc_arb_id,
    output wire [3:0] da_arb_id
);
    reg ovf_flag_reg, armed_reg, arb3_reg, drive_a_reg, drive_b_reg;
    reg ld_fall_en_reg, ld_rise_en_reg, load_pend_reg;
    reg [2:0] irq_lvl_reg, clk_sel_reg;
    reg [15:0] cnt_reg, cnt_next, ml_reg;
    reg c1_reg, c2_reg, c3_reg, clk_lvl_reg;
    reg l1_reg, l2_reg, l3_reg, ld_lvl_reg;
    reg tick;
    wire wr_mc_sic, wr_cnt, wr_ml, rd_mc_sic;
    wire wr_da_sic, wr_da_a, wr_da_b, rd_da_sic;
    wire c_agree, l_agree, ext_rise, ext_fall, ld_rise, ld_fall, ld_edge;
    wire ovf, mc_pend, da_flag;
    wire [2:0] da_irq_lvl;
    wire [15:0] mc_sic_val, da_sic_val, da_a_val, da_b_val;

    // request line for a level, none at level zero
    function [7:1] level_line;
        input [2:0] lvl;
        input pend;
        integer i;
        begin
            level_line = 7'h00;
            for (i = 1; i < 8; i = i + 1) begin
                if (pend && lvl == i[2:0]) begin
                    level_line[i] = 1'b1;
                end
            end
        end
    endfunction

    // register decode
    assign wr_mc_sic = bus_sel && bus_wr && bus_addr == `MCDT_OFS_MC_SIC;
    assign rd_mc_sic = bus_sel && !bus_wr && bus_addr == `MCDT_OFS_MC_SIC;
    assign wr_cnt = bus_sel && bus_wr && bus_addr == `MCDT_OFS_MC_CNT;
    assign wr_ml = bus_sel && bus_wr && bus_addr == `MCDT_OFS_MC_ML;
    assign wr_da_sic = bus_sel && bus_wr && bus_addr == `MCDT_OFS_DA_SIC;
    assign rd_da_sic = bus_sel && !bus_wr && bus_addr == `MCDT_OFS_DA_SIC;
    assign wr_da_a = bus_sel && bus_wr && bus_addr == `MCDT_OFS_DA_A;
    assign wr_da_b = bus_sel && bus_wr && bus_addr == `MCDT_OFS_DA_B;

    // three-stage filter assumes pin slower than clk/4
    // status bits and edges lag the pins by about three clocks
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            c1_reg <= 1'b0;
            c2_reg <= 1'b0;
            c3_reg <= 1'b0;
            clk_lvl_reg <= 1'b0;
            l1_reg <= 1'b0;
            l2_reg <= 1'b0;
            l3_reg <= 1'b0;
            ld_lvl_reg <= 1'b0;
        end else begin
            c1_reg <= external_counter_clock_pin;
            c2_reg <= c1_reg;
            c3_reg <= c2_reg;
            l1_reg <= modulus_load_pin;
            l2_reg <= l1_reg;
            l3_reg <= l2_reg;
            if (c_agree) begin
                clk_lvl_reg <= c3_reg;
            end
            if (l_agree) begin
                ld_lvl_reg <= l3_reg;
            end
        end
    end

    assign c_agree = c2_reg == c3_reg;
    assign l_agree = l2_reg == l3_reg;
    assign ext_rise = c_agree && c3_reg && !clk_lvl_reg;
    assign ext_fall = c_agree && !c3_reg && clk_lvl_reg;
    assign ld_rise = l_agree && l3_reg && !ld_lvl_reg;
    assign ld_fall = l_agree && !l3_reg && ld_lvl_reg;
    assign ld_edge = (ld_rise_en_reg && ld_rise) ||
        (ld_fall_en_reg && ld_fall);

    always @* begin
        case (clk_sel_reg)
            3'h0: tick = pclk_tick[0];
            3'h1: tick = pclk_tick[1];
            3'h2: tick = pclk_tick[2];
            3'h3: tick = pclk_tick[3];
            3'h4: tick = pclk_tick[4];
            3'h5: tick = pclk_tick[5];
            `MCDT_CLK_EXT_FALL: tick = ext_fall;
            `MCDT_CLK_EXT_RISE: tick = ext_rise;
            default: tick = 1'b0;
        endcase
    end

    // overflow is a counted step out of all ones
    assign ovf = tick && cnt_reg == `MCDT_CNT_MAX && !wr_cnt &&
        !load_pend_reg;

    // counter next value; write beats load beats count
    always @* begin
        cnt_next = cnt_reg;
        if (wr_cnt) begin
            cnt_next = bus_wdata;
        end else if (load_pend_reg) begin
            cnt_next = ml_reg;
        end else if (ovf) begin
            cnt_next = ml_reg;
        end else if (tick) begin
            cnt_next = cnt_reg + 16'h0001;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ovf_flag_reg <= 1'b0;
            armed_reg <= 1'b0;
            irq_lvl_reg <= `MCDT_LVL_OFF;
            arb3_reg <= 1'b0;
            drive_a_reg <= 1'b0;
            drive_b_reg <= 1'b0;
            ld_fall_en_reg <= 1'b0;
            ld_rise_en_reg <= 1'b0;
            clk_sel_reg <= 3'h0;
            cnt_reg <= `MCDT_CNT_RESET;
            ml_reg <= `MCDT_ML_RESET;
            load_pend_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            load_pend_reg <= ld_edge;
            // latch follows counter or own write
            if (wr_cnt || wr_ml) begin
                ml_reg <= bus_wdata;
            end
            if (wr_mc_sic) begin
                irq_lvl_reg <= bus_wdata[`MCDT_LVL_HI:`MCDT_LVL_LO];
                arb3_reg <= bus_wdata[`MCDT_ARB3_BIT];
                drive_a_reg <= bus_wdata[`MCDT_DRIVE_A_BIT];
                drive_b_reg <= bus_wdata[`MCDT_DRIVE_B_BIT];
                ld_fall_en_reg <= bus_wdata[`MCDT_LD_FALL_BIT];
                ld_rise_en_reg <= bus_wdata[`MCDT_LD_RISE_BIT];
                clk_sel_reg <= bus_wdata[`MCDT_CLK_HI:`MCDT_CLK_LO];
            end
            // set wins over a same-cycle clear
            if (ovf) begin
                ovf_flag_reg <= 1'b1;
            end else if (wr_mc_sic && armed_reg &&
                    !bus_wdata[`MCDT_FLAG_BIT]) begin
                ovf_flag_reg <= 1'b0;
            end
            // clear needs a prior read showing one
            if (rd_mc_sic && ovf_flag_reg) begin
                armed_reg <= 1'b1;
            end else if (wr_mc_sic) begin
                armed_reg <= 1'b0;
            end
        end
    end

    // pin levels clear on reset but bypass writes
    // pin bits come from the filter, so writes cannot touch them
    assign mc_sic_val = {ovf_flag_reg, irq_lvl_reg, arb3_reg, 1'b0,
        drive_a_reg, drive_b_reg, clk_lvl_reg, ld_lvl_reg, ld_fall_en_reg,
        ld_rise_en_reg, 1'b0, clk_sel_reg};

    // read data and ack one cycle after the strobe
    // unmapped offsets still ack so a host never waits forever
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus_rdata <= 16'h0000;
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= bus_sel;
            if (bus_sel && !bus_wr) begin
                case (bus_addr)
                    `MCDT_OFS_MC_SIC: bus_rdata <= mc_sic_val;
                    `MCDT_OFS_MC_CNT: bus_rdata <= cnt_reg;
                    `MCDT_OFS_MC_ML: bus_rdata <= ml_reg;
                    `MCDT_OFS_DA_SIC: bus_rdata <= da_sic_val;
                    `MCDT_OFS_DA_A: bus_rdata <= da_a_val;
                    `MCDT_OFS_DA_B: bus_rdata <= da_b_val;
                    default: bus_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // time base bus drive, from registered count
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tbb_a_out <= 16'h0000;
            tbb_b_out <= 16'h0000;
            tbb_a_oe <= 1'b0;
            tbb_b_oe <= 1'b0;
        end else begin
            tbb_a_out <= cnt_next;
            tbb_b_out <= cnt_next;
            tbb_a_oe <= wr_mc_sic ? bus_wdata[`MCDT_DRIVE_A_BIT] :
                drive_a_reg;
            tbb_b_oe <= wr_mc_sic ? bus_wdata[`MCDT_DRIVE_B_BIT] :
                drive_b_reg;
        end
    end

    mcdt_dual u_dual (
        .clk(clk),
        .rstn(rstn),
        .sic_wr(wr_da_sic),
        .sic_rd(rd_da_sic),
        .a_wr(wr_da_a),
        .b_wr(wr_da_b),
        .wdata(bus_wdata),
        .tbb_a(tbb_a_in),
        .tbb_b(tbb_b_in),
        .pin_in(da_pin_in),
        .pin_out(da_pin_out),
        .pin_oe(da_pin_oe),
        .sic_val(da_sic_val),
        .a_val(da_a_val),
        .b_val(da_b_val),
        .flag(da_flag),
        .irq_lvl(da_irq_lvl)
    );

    assign mc_pend = ovf_flag_reg && irq_lvl_reg != `MCDT_LVL_OFF;
    // level zero maps to no line, so a disabled source stays silent
    assign irq_req = level_line(irq_lvl_reg, ovf_flag_reg) |
        level_line(da_irq_lvl, da_flag);
    // respond only to an ack at our own level
    assign mc_iack_hit = iack_strobe && mc_pend && iack_level == irq_lvl_reg;
    assign da_iack_hit = iack_strobe && da_flag &&
        da_irq_lvl != `MCDT_LVL_OFF && iack_level == da_irq_lvl;
    assign mc_arb_id = {arb3_reg, module_arb_field};
    assign da_arb_id = {da_sic_val[`MCDT_ARB3_BIT], module_arb_field};
endmodule // mcdt_top

// ==== verif/mcdt_host.sv ====
// host model that drives the submodule register bus
`timescale 1ns/100ps
module mcdt_host (
    // clock
    input wire clk,
    // register bus
    output logic sel,
    output logic wr,
    output logic [7:0] addr,
    output logic [15:0] wd,
    input wire [15:0] rd,
    input wire ack
);
initial begin
    sel = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wd = 16'h0000;
end
// one-cycle strobe; answer is taken while ack stands
task acc(input logic w, input logic [7:0] a, input logic [15:0] d,
         output logic [15:0] r);
    @(negedge clk);
    sel = 1'b1;
    wr = w;
    addr = a;
    wd = d;
    @(negedge clk);
    r = (ack === 1'b1) ? rd : 16'hdead;
    sel = 1'b0;
    // idle bus shows garbage, not the last value
    addr = ~a;
    wd = ~d;
endtask
endmodule // mcdt_host

// ==== verif/mcdt_asserts.sv ====
// port checker for the timer block
`timescale 1ns/100ps
module mcdt_asserts (
    // clock and reset
    input wire clk,
    input wire rstn,
    // register bus
    input wire bus_sel,
    input wire bus_wr,
    input wire [7:0] bus_addr,
    input wire [15:0] bus_rdata,
    input wire bus_ack,
    // arbitration, interrupts, bus drive
    input wire [2:0] module_arb_field,
    input wire [3:0] mc_arb_id,
    input wire [3:0] da_arb_id,
    input wire [7:1] irq_req,
    input wire [2:0] iack_level,
    input wire mc_iack_hit,
    input wire da_iack_hit,
    input wire tbb_a_oe,
    input wire tbb_b_oe
);
default clocking @(posedge clk); endclocking
default disable iff (!rstn);
wire rd_go = bus_sel && !bus_wr;
wire mc_wr = bus_sel && bus_wr && bus_addr == 8'h10;
a_ack_follows_sel: assert property (bus_sel |=> bus_ack)
    else $error("no ack after strobe");
a_ack_needs_sel: assert property (bus_ack |-> $past(bus_sel))
    else $error("ack without strobe");
a_rdata_holds: assert property (!$past(rd_go) |-> $stable(bus_rdata))
    else $error("read data moved without read");
a_unmapped_zero: assert property (
    rd_go && bus_addr == 8'h16 |=> bus_rdata == 16'h0000)
    else $error("unmapped read not zero");
a_force_reads_zero: assert property (
    rd_go && bus_addr == 8'h18 |=> bus_rdata[6:5] == 2'b00)
    else $error("force bits read nonzero");
a_mc_arb_id: assert property (mc_arb_id[2:0] == module_arb_field)
    else $error("counter arbitration id wrong");
a_da_arb_id: assert property (da_arb_id[2:0] == module_arb_field)
    else $error("channel arbitration id wrong");
a_mc_ack_level: assert property (
    mc_iack_hit |-> iack_level != 3'h0 && irq_req[iack_level])
    else $error("counter ack at wrong level");
a_da_ack_level: assert property (
    da_iack_hit |-> iack_level != 3'h0 && irq_req[iack_level])
    else $error("channel ack at wrong level");
a_drive_by_write: assert property (
    $changed({tbb_a_oe, tbb_b_oe}) |-> $past(mc_wr))
    else $error("bus drive changed without write");
endmodule // mcdt_asserts
bind mcdt_top mcdt_asserts i_chk (.clk, .rstn, .bus_sel, .bus_wr, .bus_addr,
    .bus_rdata, .bus_ack, .module_arb_field, .mc_arb_id, .da_arb_id,
    .irq_req, .iack_level, .mc_iack_hit, .da_iack_hit, .tbb_a_oe, .tbb_b_oe);

// ==== verif/testbench.sv ====
// self-checking testbench for the timer block
`timescale 1ns/100ps
module testbench;
logic clk = 0, rstn = 0, ext = 0, ld = 0, dpin = 0, istb = 0;
logic [5:0] tick = 6'h00;
logic [2:0] arb = 3'h0, ilv = 3'h0;
logic [15:0] ta = 16'h0000, tb = 16'h0000, v;
wire sel, wr, ack, aoe, boe, pout, poe, mhit, dhit;
wire [7:0] addr;
wire [15:0] wd, rd, ao, bo;
wire [7:1] irq;
wire [3:0] maid, daid;
int bad_count = 0, cmp_count = 0;
always #2.5 clk = ~clk;
mcdt_host i_host (.clk, .sel, .wr, .addr, .wd, .rd, .ack);
mcdt_top i_dut (.clk, .rstn, .bus_sel(sel), .bus_wr(wr), .bus_addr(addr),
    .bus_wdata(wd), .bus_rdata(rd), .bus_ack(ack), .pclk_tick(tick),
    .module_arb_field(arb), .external_counter_clock_pin(ext),
    .modulus_load_pin(ld), .tbb_a_in(ta), .tbb_b_in(tb), .tbb_a_out(ao),
    .tbb_a_oe(aoe), .tbb_b_out(bo), .tbb_b_oe(boe), .da_pin_in(dpin),
    .da_pin_out(pout), .da_pin_oe(poe), .irq_req(irq), .iack_strobe(istb),
    .iack_level(ilv), .mc_iack_hit(mhit), .da_iack_hit(dhit),
    .mc_arb_id(maid), .da_arb_id(daid));
task results();
    if (bad_count == 0 && cmp_count > 0) begin
        $display("*** PASS ***");
    end else begin
        $display("*** FAIL ***");
    end
    $finish;
endtask
task chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
        bad_count++;
        $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
endtask
task wr16(input logic [7:0] a, input logic [15:0] d);
    i_host.acc(1'b1, a, d, v);
endtask
task rd16(input logic [7:0] a, input logic [15:0] e);
    i_host.acc(1'b0, a, 16'h0000, v);
    chk(v, e);
endtask
task cyc(input int n);
    repeat (n) @(negedge clk);
endtask
task pulse(input int k);
    @(negedge clk) tick = 6'h01 << k;
    @(negedge clk) tick = 6'h00;
endtask
initial begin
    cyc(16);
    rstn = 1'b1;
    cyc(2);
    rd16(8'h14, 16'h0000);
    rd16(8'h16, 16'h0000);
    wr16(8'h12, 16'hfffe);
    rd16(8'h14, 16'hfffe);
    wr16(8'h14, 16'h00a0);
    rd16(8'h12, 16'hfffe);
    wr16(8'h10, 16'h3000);
    repeat (2) pulse(0);
    rd16(8'h12, 16'h00a0);
    // write without a prior read must not clear
    wr16(8'h10, 16'h3000);
    rd16(8'h10, 16'hb000);
    chk({9'h000, irq}, 16'h0004);
    ilv = 3'h3;
    istb = 1'b1;
    cyc(1);
    chk({15'h0000, mhit}, 16'h0001);
    wr16(8'h10, 16'h3000);
    rd16(8'h10, 16'h3000);
    chk({9'h000, irq}, 16'h0000);
    for (int c = 0; c < 6; c++) begin
        wr16(8'h10, {13'h0000, c[2:0]});
        wr16(8'h12, 16'h0100);
        pulse(c);
        pulse((c + 1) % 6);
        rd16(8'h12, 16'h0101);
    end
    for (int c = 6; c < 8; c++) begin
        wr16(8'h10, {13'h0000, c[2:0]});
        wr16(8'h12, 16'h0200);
        ext = 1'b1;
        cyc(8);
        ext = 1'b0;
        cyc(8);
        rd16(8'h12, 16'h0201);
    end
    for (int e = 0; e < 4; e++) begin
        wr16(8'h10, {10'h000, e[1:0], 4'h0});
        wr16(8'h12, 16'h0011);
        wr16(8'h14, 16'h0055);
        ld = 1'b1;
        cyc(8);
        rd16(8'h12, e[0] ? 16'h0055 : 16'h0011);
        rd16(8'h10, {10'h001, e[1:0], 4'h0});
        wr16(8'h14, 16'h0066);
        ld = 1'b0;
        cyc(8);
        rd16(8'h12, e[1] ? 16'h0066 : (e[0] ? 16'h0055 : 16'h0011));
    end
    ext = 1'b1;
    cyc(8);
    wr16(8'h10, 16'h00c0);
    rd16(8'h10, 16'h0080);
    for (int d = 0; d < 4; d++) begin
        wr16(8'h10, {6'h00, d[1:0], 8'h00});
        chk({14'h0000, aoe, boe}, {14'h0000, d[1:0]});
    end
    chk(ao, 16'h0066);
    chk(bo, 16'h0066);
    arb = 3'h5;
    wr16(8'h10, 16'h0800);
    chk({12'h000, maid}, 16'h000d);
    // forces act only once an output mode is already selected
    wr16(8'h18, 16'h0004);
    wr16(8'h18, 16'h0044);
    cyc(2);
    chk({15'h0000, pout}, 16'h0001);
    rd16(8'h18, 16'h0084);
    chk({15'h0000, poe}, 16'h0001);
    wr16(8'h18, 16'h0204);
    chk({15'h0000, poe}, 16'h0000);
    wr16(8'h18, 16'h0064);
    cyc(2);
    chk({15'h0000, pout}, 16'h0000);
    wr16(8'h18, 16'h2004);
    ta = 16'h0300;
    wr16(8'h1c, 16'h0300);
    cyc(4);
    chk({9'h000, irq}, 16'h0002);
    ilv = 3'h2;
    cyc(1);
    chk({15'h0000, dhit}, 16'h0001);
    // leaving for disabled mode drops the flag without a read
    wr16(8'h18, 16'h2000);
    chk({9'h000, irq}, 16'h0000);
    wr16(8'h18, 16'h0103);
    tb = 16'h0777;
    ta = 16'h0123;
    dpin = 1'b1;
    cyc(8);
    rd16(8'h1a, 16'h0777);
    rd16(8'h18, 16'h8183);
    // period mode: first capture only primes, second raises the flag
    wr16(8'h18, 16'h0002);
    dpin = 1'b0;
    cyc(8);
    dpin = 1'b1;
    cyc(8);
    rd16(8'h18, 16'h0082);
    ta = 16'h0456;
    dpin = 1'b0;
    cyc(8);
    dpin = 1'b1;
    cyc(8);
    rd16(8'h1c, 16'h0123);
    rd16(8'h18, 16'h8082);
    results();
end
// limit well beyond the roughly 370 cycles the tests need
initial begin
    #20000;
    bad_count++;
    results();
end
endmodule // testbench
